// ---- verilog/dlp_pkg.sv ----
`default_nettype none
package dlp_pkg;
    // cassette indices
    localparam int NCAS       = 2;
    localparam int CAS_RIGHT  = 0;
    localparam int CAS_LEFT   = 1;
    // timeout counter width, cycles of core_clk
    localparam int CNT_W      = 16;
    // positions in the synchronised pin vector, right at pos, left at pos+1
    localparam int P_LIFT     = 0;
    localparam int P_PICK     = 2;
    localparam int P_FEED     = 4;
    localparam int P_SIZE     = 6;
    localparam int P_OPEN     = 8;
    localparam int P_COMMON   = 10;
    localparam int P_DOOR     = 11;
    localparam int P_TRAY     = 12;
    localparam int NPIN       = 13;
    // power-up check waits for the synchronisers to fill
    localparam logic [1:0] PWR_SETTLE = 2'h2;
    localparam logic [1:0] PWR_DONE   = 2'h3;
    localparam logic [1:0] PWR_RST    = 2'h0;

    typedef enum logic {LIFT_IDLE, LIFT_RUN} dlp_lift_e;
    typedef enum logic [1:0] {PICK_IDLE, PICK_SOL, PICK_FEED} dlp_pick_e;

    typedef struct packed {
        logic [NPIN-1:0]             s1;
        logic [NPIN-1:0]             s2;
        logic [NPIN-1:0]             prev;
        logic [1:0]                  pwr_cnt;
        dlp_lift_e [NCAS-1:0]        lift;
        dlp_pick_e [NCAS-1:0]        pick;
        logic [NCAS-1:0][CNT_W-1:0]  lcnt;
        logic [NCAS-1:0][CNT_W-1:0]  pcnt;
        logic                        tray_wait;
        logic [CNT_W-1:0]            tcnt;
        logic [NCAS-1:0]             motor;
        logic [NCAS-1:0]             sol;
        logic [NCAS-1:0]             lfail;
        logic [NCAS-1:0]             present;
        logic [NCAS-1:0]             a4r;
        logic [NCAS-1:0]             jam1;
        logic [NCAS-1:0]             jam3;
        logic                        jam4;
        logic                        resid;
        logic                        door_jam;
        logic                        feeding;
    } dlp_state_s;
endpackage
`default_nettype wire

// ---- verilog/dlp_deck_ctrl.sv ----
// Function
// - both cassettes run identical, independent lift and detection logic, and identical pickup logic sharing one feed path, right winning a tie
// - start a lift at power-up, on cassette install, or when stack drops
// - during a lift drive the lifter motor to raise the tray
// - stop the lifter motor once the lift-up surface sensor sees paper
// - while printing, relift whenever the stack surface has fallen
// - flag lifter failure if surface not seen within lift timeout
// - report media size, A4 rotated or Letter rotated, from size sensor
// - report cassette presence from the cassette open switch
// - freeze size and presence detection during active-off
// - no-pick jam 1 if cassette feed sensor misses edge after solenoid
// - no-pick jam 3 if common feed sensor misses edge after cassette sensor
// - jam 4 if tray 1 feed sensor misses edge after common sensor
// - residual jam if a cassette feed sensor or the common feed sensor shows paper at checkpoints
// - right-door-open jam if door opens while a sheet feeds
// - pickup motor failures surface only as jam reports
`timescale 1ns/1ps
`default_nettype none
module dlp_deck_ctrl
    import dlp_pkg::*;
(
    input  wire logic             core_clk,
    input  wire logic             sys_rst,
    input  wire logic             right_liftup_surface_sensor,
    input  wire logic             left_liftup_surface_sensor,
    input  wire logic             right_pick_surface_sensor,
    input  wire logic             left_pick_surface_sensor,
    input  wire logic             right_feed_sensor,
    input  wire logic             left_feed_sensor,
    input  wire logic             right_size_sensor,
    input  wire logic             left_size_sensor,
    input  wire logic             right_cassette_open_switch,
    input  wire logic             left_cassette_open_switch,
    input  wire logic             common_feed_sensor,
    input  wire logic             right_door_switch,
    input  wire logic             tray1_feed_sensor,
    input  wire logic             active_off,
    input  wire logic             printing,
    input  wire logic             wake_evt,
    input  wire logic             right_pick_req,
    input  wire logic             left_pick_req,
    input  wire logic             jam_clear,
    input  wire logic [CNT_W-1:0] lift_tmo,
    input  wire logic [CNT_W-1:0] pick_tmo,
    input  wire logic [CNT_W-1:0] feed_tmo,
    input  wire logic [CNT_W-1:0] tray_tmo,
    output logic                  right_lifter_motor,
    output logic                  left_lifter_motor,
    output logic                  right_pick_solenoid,
    output logic                  left_pick_solenoid,
    output logic                  right_lift_fail,
    output logic                  left_lift_fail,
    output logic                  right_present,
    output logic                  left_present,
    output logic                  right_size_a4r,
    output logic                  left_size_a4r,
    output logic                  right_nopick1_jam,
    output logic                  left_nopick1_jam,
    output logic                  right_nopick3_jam,
    output logic                  left_nopick3_jam,
    output logic                  nopick4_jam,
    output logic                  residual_jam,
    output logic                  door_open_jam,
    output logic                  feed_busy
);

    dlp_state_s            st_r;
    dlp_state_s            st_nxt;
    logic [NPIN-1:0]       pins;
    logic [NPIN-1:0]       pin_rise;
    logic                  pwr_evt;
    logic                  any_flag;
    logic                  door_trip;
    logic                  abort_feed;
    logic                  resid_chk;
    logic [NCAS-1:0]       pick_req;

    // per-cassette pin lookup, used all over the decode
    function automatic logic pin_of(input logic [NPIN-1:0] v,
                                    input int pos,
                                    input int c);
        pin_of = v[pos+c];
    endfunction

    // raw pins gathered for the synchronisers
    assign pins = {tray1_feed_sensor, right_door_switch, common_feed_sensor,
                   left_cassette_open_switch, right_cassette_open_switch,
                   left_size_sensor, right_size_sensor,
                   left_feed_sensor, right_feed_sensor,
                   left_pick_surface_sensor, right_pick_surface_sensor,
                   left_liftup_surface_sensor, right_liftup_surface_sensor};
    assign pick_req = {left_pick_req, right_pick_req};

    // edges and shared conditions, on synchronised copies except the raw wake_evt input
    assign pin_rise   = st_r.s2 & ~st_r.prev;
    assign pwr_evt    = (st_r.pwr_cnt == PWR_SETTLE);
    assign any_flag   = (|st_r.lfail) | (|st_r.jam1) | (|st_r.jam3)
                      | st_r.jam4 | st_r.resid | st_r.door_jam;
    assign door_trip  = st_r.feeding & st_r.s2[P_DOOR];
    assign abort_feed = any_flag | door_trip;
    // door closing is a falling edge of the open switch
    assign resid_chk  = pwr_evt | wake_evt
                      | (st_r.prev[P_DOOR] & ~st_r.s2[P_DOOR]);

    // next-state logic for the whole controller
    always_comb begin
        logic busy;
        logic cas_in;
        logic surf;
        logic start;
        busy   = st_r.feeding;
        cas_in = 1'b0;
        surf   = 1'b0;
        start  = 1'b0;
        st_nxt = st_r;
        st_nxt.s1   = pins;
        st_nxt.s2   = st_r.s1;
        st_nxt.prev = st_r.s2;
        if (st_r.pwr_cnt != PWR_DONE) begin
            st_nxt.pwr_cnt = st_r.pwr_cnt + 2'h1;
        end
        // clear first, so a set in the same cycle wins
        if (jam_clear) begin
            st_nxt.lfail    = '0;
            st_nxt.jam1     = '0;
            st_nxt.jam3     = '0;
            st_nxt.jam4     = 1'b0;
            st_nxt.resid    = 1'b0;
            st_nxt.door_jam = 1'b0;
        end
        for (int c = 0; c < NCAS; c++) begin
            cas_in = ~pin_of(st_r.s2, P_OPEN, c)
                   & (st_r.pwr_cnt >= PWR_SETTLE); // reset zeros read as in
            surf   = pin_of(st_r.s2, P_LIFT, c);
            // detection frozen while the machine sleeps in active-off
            if (!active_off) begin
                st_nxt.present[c] = cas_in;
                if (cas_in) begin
                    st_nxt.a4r[c] = pin_of(st_r.s2, P_SIZE, c);
                end
            end
            start = (pwr_evt
                  || (!active_off && !st_r.present[c])
                  || (printing && st_r.present[c]))
                  && cas_in && !surf && !st_r.lfail[c];
            case (st_r.lift[c])
                LIFT_IDLE: begin
                    st_nxt.lcnt[c] = '0;
                    if (start) begin
                        st_nxt.lift[c]  = LIFT_RUN;
                        st_nxt.motor[c] = 1'b1;
                    end
                end
                LIFT_RUN: begin
                    if (!cas_in || surf) begin
                        st_nxt.lift[c]  = LIFT_IDLE;
                        st_nxt.motor[c] = 1'b0;
                    end else if (st_r.lcnt[c] >= lift_tmo) begin
                        st_nxt.lift[c]  = LIFT_IDLE;
                        st_nxt.motor[c] = 1'b0;
                        st_nxt.lfail[c] = 1'b1;
                    end else begin
                        st_nxt.lcnt[c] = st_r.lcnt[c] + 1'b1;
                    end
                end
                default: begin
                    st_nxt.lift[c]  = LIFT_IDLE;
                    st_nxt.motor[c] = 1'b0;
                end
            endcase
            // pickup; a stalled pickup motor only shows as a jam
            case (st_r.pick[c])
                PICK_IDLE: begin
                    st_nxt.pcnt[c] = '0;
                    if (pick_req[c] && !busy && !abort_feed
                        && st_r.present[c] && st_r.lift[c] == LIFT_IDLE
                        && pin_of(st_r.s2, P_PICK, c)) begin
                        busy              = 1'b1; // right wins a tie
                        st_nxt.pick[c]    = PICK_SOL;
                        st_nxt.sol[c]     = 1'b1;
                    end
                end
                PICK_SOL: begin
                    if (pin_of(pin_rise, P_FEED, c)) begin
                        st_nxt.pick[c] = PICK_FEED;
                        st_nxt.sol[c]  = 1'b0;
                        st_nxt.pcnt[c] = '0;
                    end else if (st_r.pcnt[c] >= pick_tmo) begin
                        st_nxt.pick[c] = PICK_IDLE;
                        st_nxt.sol[c]  = 1'b0;
                        st_nxt.jam1[c] = 1'b1;
                    end else begin
                        st_nxt.pcnt[c] = st_r.pcnt[c] + 1'b1;
                    end
                end
                PICK_FEED: begin
                    if (pin_rise[P_COMMON]) begin
                        st_nxt.pick[c]    = PICK_IDLE;
                        st_nxt.tray_wait  = 1'b1;
                        st_nxt.tcnt       = '0;
                    end else if (st_r.pcnt[c] >= feed_tmo) begin
                        st_nxt.pick[c] = PICK_IDLE;
                        st_nxt.jam3[c] = 1'b1;
                    end else begin
                        st_nxt.pcnt[c] = st_r.pcnt[c] + 1'b1;
                    end
                end
                default: begin
                    st_nxt.pick[c] = PICK_IDLE;
                    st_nxt.sol[c]  = 1'b0;
                end
            endcase
        end
        // hand-off into the printer's tray 1 path
        if (st_r.tray_wait) begin
            if (pin_rise[P_TRAY]) begin
                st_nxt.tray_wait = 1'b0;
            end else if (st_r.tcnt >= tray_tmo) begin
                st_nxt.tray_wait = 1'b0;
                st_nxt.jam4      = 1'b1;
            end else begin
                st_nxt.tcnt = st_r.tcnt + 1'b1;
            end
        end
        // sheets left in the path at a checkpoint
        if (resid_chk && (st_r.s2[P_FEED] || st_r.s2[P_FEED+1]
                          || st_r.s2[P_COMMON])) begin
            st_nxt.resid = 1'b1;
        end
        if (door_trip) begin
            st_nxt.door_jam = 1'b1;
        end
        // a latched flag halts every sheet in flight
        if (abort_feed) begin
            st_nxt.pick      = {PICK_IDLE, PICK_IDLE};
            st_nxt.sol       = '0;
            st_nxt.tray_wait = 1'b0;
        end
        st_nxt.feeding = (st_nxt.pick[0] != PICK_IDLE)
                       || (st_nxt.pick[1] != PICK_IDLE) || st_nxt.tray_wait;
    end

    // single state register
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the state register
    assign right_lifter_motor  = st_r.motor[CAS_RIGHT];
    assign left_lifter_motor   = st_r.motor[CAS_LEFT];
    assign right_pick_solenoid = st_r.sol[CAS_RIGHT];
    assign left_pick_solenoid  = st_r.sol[CAS_LEFT];
    assign right_lift_fail     = st_r.lfail[CAS_RIGHT];
    assign left_lift_fail      = st_r.lfail[CAS_LEFT];
    assign right_present       = st_r.present[CAS_RIGHT];
    assign left_present        = st_r.present[CAS_LEFT];
    assign right_size_a4r      = st_r.a4r[CAS_RIGHT];
    assign left_size_a4r       = st_r.a4r[CAS_LEFT];
    assign right_nopick1_jam   = st_r.jam1[CAS_RIGHT];
    assign left_nopick1_jam    = st_r.jam1[CAS_LEFT];
    assign right_nopick3_jam   = st_r.jam3[CAS_RIGHT];
    assign left_nopick3_jam    = st_r.jam3[CAS_LEFT];
    assign nopick4_jam         = st_r.jam4;
    assign residual_jam        = st_r.resid;
    assign door_open_jam       = st_r.door_jam;
    assign feed_busy           = st_r.feeding;

    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    // checks repeated per cassette
    for (genvar g = 0; g < NCAS; g++) begin : g_chk
        sequence lift_hit_s;
            st_r.lift[g] == LIFT_RUN && st_r.s2[P_LIFT+g];
        endsequence
        sequence feed_seen_s;
            st_r.pick[g] == PICK_SOL && pin_rise[P_FEED+g] && !abort_feed;
        endsequence
        motor_stop_a: assert property (
            lift_hit_s |=> !st_r.motor[g] && st_r.lift[g] == LIFT_IDLE)
            else $error("lifter motor kept running at surface");
        lift_fail_a: assert property (
            st_r.lift[g] == LIFT_RUN && !st_r.s2[P_LIFT+g]
            && !st_r.s2[P_OPEN+g] && st_r.lcnt[g] >= lift_tmo
            |=> st_r.lfail[g] && !st_r.motor[g])
            else $error("lift timeout did not flag failure");
        relift_a: assert property (
            st_r.lift[g] == LIFT_IDLE && printing && st_r.present[g]
            && !st_r.s2[P_OPEN+g] && !st_r.s2[P_LIFT+g] && !st_r.lfail[g]
            |=> st_r.motor[g] && st_r.lift[g] == LIFT_RUN)
            else $error("fallen stack not relifted");
        freeze_a: assert property (
            active_off |=> $stable(st_r.present[g]) && $stable(st_r.a4r[g]))
            else $error("detection ran in active-off");
        size_rep_a: assert property (
            !active_off && !st_r.s2[P_OPEN+g]
            |=> st_r.a4r[g] == $past(st_r.s2[P_SIZE+g]))
            else $error("size report wrong");
        feed_step_a: assert property (
            feed_seen_s |=> st_r.pick[g] == PICK_FEED && !st_r.sol[g])
            else $error("feed edge did not end solenoid phase");
        nopick1_a: assert property (
            st_r.pick[g] == PICK_SOL && !pin_rise[P_FEED+g]
            && st_r.pcnt[g] >= pick_tmo |=> st_r.jam1[g])
            else $error("no-pick jam 1 missed");
        nopick3_a: assert property (
            st_r.pick[g] == PICK_FEED && !pin_rise[P_COMMON]
            && st_r.pcnt[g] >= feed_tmo |=> st_r.jam3[g])
            else $error("no-pick jam 3 missed");
    end

    nopick4_a: assert property (
        st_r.tray_wait && !pin_rise[P_TRAY] && st_r.tcnt >= tray_tmo
        |=> st_r.jam4 && !st_r.feeding)
        else $error("jam 4 missed");
    door_jam_a: assert property (
        st_r.feeding && st_r.s2[P_DOOR] |=> st_r.door_jam ##1 !st_r.feeding)
        else $error("door open during feed not caught");
    resid_a: assert property (
        wake_evt && (st_r.s2[P_FEED] || st_r.s2[P_COMMON]) |=> st_r.resid)
        else $error("residual paper not flagged");
    flag_hold_a: assert property (
        any_flag && !jam_clear |=> any_flag)
        else $error("flag dropped without clear");
    no_feed_a: assert property (
        any_flag |=> !(|st_r.sol) && !st_r.feeding)
        else $error("feeding continued under a flag");

endmodule // dlp_deck_ctrl
`default_nettype wire

// ---- verification/dlp_path_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// sheet path seen from the deck: cassette, common and tray-1 feed sensors
module dlp_path_model (
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    input  wire logic       right_pick_solenoid,
    input  wire logic       left_pick_solenoid,
    input  wire logic [1:0] fault,
    output logic            right_feed_sensor,
    output logic            left_feed_sensor,
    output logic            common_feed_sensor,
    output logic            tray1_feed_sensor
);
    logic       act_r;
    logic       cas_r;
    logic [4:0] cnt_r;
    logic [1:0] sol_r;
    logic       fd;
    // a sheet starts on a solenoid rise; a stalled sheet waits for fault 0
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            act_r <= 1'b0;
            cas_r <= 1'b0;
            cnt_r <= 5'h00;
            sol_r <= 2'h0;
        end else begin
            sol_r <= {left_pick_solenoid, right_pick_solenoid};
            if (!act_r && ((right_pick_solenoid && !sol_r[0]) ||
                           (left_pick_solenoid && !sol_r[1]))) begin
                act_r <= 1'b1;
                cas_r <= left_pick_solenoid;
                cnt_r <= 5'h00;
            end else if (act_r && cnt_r != 5'h1e) begin
                cnt_r <= cnt_r + 5'h01;
            end else if (act_r && fault == 2'h0) begin
                act_r <= 1'b0;
            end
        end
    end
    // fault 1 loses the sheet, 2 stalls it at the cassette, 3 at common
    assign fd = act_r && cnt_r >= 5'h05 && fault != 2'h1 &&
                (cnt_r < 5'h0a || fault == 2'h2);
    assign right_feed_sensor = fd && !cas_r;
    assign left_feed_sensor = fd && cas_r;
    assign common_feed_sensor = act_r && cnt_r >= 5'h0a && fault[1] == 1'b0
                                && fault != 2'h1 || act_r && fault == 2'h3
                                && cnt_r >= 5'h0a;
    assign tray1_feed_sensor = act_r && fault == 2'h0 && cnt_r >= 5'h0e &&
                               cnt_r < 5'h12;
endmodule // dlp_path_model
`default_nettype wire

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import dlp_pkg::*;
    localparam int RM = 0, RS = 2, RF = 4, RP = 6, RA = 8, RJ1 = 10;
    localparam int RJ3 = 12, J4 = 14, RES = 15, DOOR = 16, BUSY = 17;
    localparam logic [CNT_W-1:0] LTMO = 16'h0014, PTMO = 16'h000c;
    logic core_clk, sys_rst, active_off, printing, wake_evt, jam_clear;
    logic right_liftup_surface_sensor, left_liftup_surface_sensor;
    logic right_pick_surface_sensor, left_pick_surface_sensor;
    logic right_size_sensor, left_size_sensor, right_door_switch;
    logic right_cassette_open_switch, left_cassette_open_switch;
    logic right_pick_req, left_pick_req;
    logic [1:0] fault;
    logic right_feed_sensor, left_feed_sensor, common_feed_sensor;
    logic tray1_feed_sensor, right_lifter_motor, left_lifter_motor;
    logic right_pick_solenoid, left_pick_solenoid, right_lift_fail;
    logic left_lift_fail, right_present, left_present, right_size_a4r;
    logic left_size_a4r, right_nopick1_jam, left_nopick1_jam;
    logic right_nopick3_jam, left_nopick3_jam, nopick4_jam, residual_jam;
    logic door_open_jam, feed_busy;
    wire logic [17:0] o;
    int tests_run, fails, cyc;
    // outputs gathered so scenarios can index them
    assign o = {feed_busy, door_open_jam, residual_jam, nopick4_jam,
        left_nopick3_jam, right_nopick3_jam, left_nopick1_jam,
        right_nopick1_jam, left_size_a4r, right_size_a4r, left_present,
        right_present, left_lift_fail, right_lift_fail, left_pick_solenoid,
        right_pick_solenoid, left_lifter_motor, right_lifter_motor};
    dlp_deck_ctrl dut (.core_clk, .sys_rst, .right_liftup_surface_sensor,
        .left_liftup_surface_sensor, .right_pick_surface_sensor,
        .left_pick_surface_sensor, .right_feed_sensor, .left_feed_sensor,
        .right_size_sensor, .left_size_sensor, .right_cassette_open_switch,
        .left_cassette_open_switch, .common_feed_sensor, .right_door_switch,
        .tray1_feed_sensor, .active_off, .printing, .wake_evt,
        .right_pick_req, .left_pick_req, .jam_clear, .lift_tmo(LTMO),
        .pick_tmo(PTMO), .feed_tmo(PTMO), .tray_tmo(PTMO),
        .right_lifter_motor, .left_lifter_motor, .right_pick_solenoid,
        .left_pick_solenoid, .right_lift_fail, .left_lift_fail,
        .right_present, .left_present, .right_size_a4r, .left_size_a4r,
        .right_nopick1_jam, .left_nopick1_jam, .right_nopick3_jam,
        .left_nopick3_jam, .nopick4_jam, .residual_jam, .door_open_jam,
        .feed_busy);
    dlp_path_model model (.core_clk, .sys_rst, .right_pick_solenoid,
        .left_pick_solenoid, .fault, .right_feed_sensor, .left_feed_sensor,
        .common_feed_sensor, .tray1_feed_sensor);
    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic check(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t ns: got %b expected %b", $time, got, exp);
        end
    endtask
    // inputs always move 1 ns after the rising edge
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // bounded wait so a dead output cannot hang the run
    task automatic wait_bit(input int idx, input logic val, input int lim);
        int k;
        k = 0;
        while (o[idx] !== val && k < lim) begin
            step(1);
            k++;
        end
        check(o[idx], val);
    endtask
    task automatic pick(input int c);
        right_pick_req = (c == 0);
        left_pick_req = (c == 1);
        step(1);
        right_pick_req = 1'b0;
        left_pick_req = 1'b0;
    endtask
    task automatic clear_flags();
        jam_clear = 1'b1;
        step(1);
        jam_clear = 1'b0;
        step(2);
    endtask
    task automatic t_power_lift();
        check(o[RM], 1'b0);
        wait_bit(RM, 1'b1, 6);
        check(o[RM+1], 1'b1);
        check(o[RP], 1'b1);
        check(o[RP+1], 1'b1);
        check(o[RA], 1'b1);
        check(o[RA+1], 1'b0);
        right_liftup_surface_sensor = 1'b1;
        wait_bit(RM, 1'b0, 6);
        check(o[RM+1], 1'b1);
        left_liftup_surface_sensor = 1'b1;
        wait_bit(RM+1, 1'b0, 6);
    endtask
    task automatic t_relift_fail();
        printing = 1'b1;
        right_liftup_surface_sensor = 1'b0;
        wait_bit(RM, 1'b1, 6);
        right_liftup_surface_sensor = 1'b1;
        wait_bit(RM, 1'b0, 6);
        left_liftup_surface_sensor = 1'b0;
        wait_bit(RM+1, 1'b1, 6);
        step(int'(LTMO) - 4);
        check(o[RF+1], 1'b0);
        wait_bit(RF+1, 1'b1, 10);
        check(o[RM+1], 1'b0);
        check(o[RF], 1'b0);
        step(6);
        check(o[RM+1], 1'b0);
        left_liftup_surface_sensor = 1'b1;
        printing = 1'b0;
        step(4);
        clear_flags();
        check(o[RF+1], 1'b0);
    endtask
    task automatic t_pick_ok(input int c);
        fault = 2'h0;
        pick(c);
        check(o[RS+c], 1'b1);
        check(o[BUSY], 1'b1);
        wait_bit(BUSY, 1'b0, 40);
        check(o[RJ1+c] | o[RJ3+c] | o[J4], 1'b0);
        // the sheet tail still covers the common sensor; let it leave
        step(16);
    endtask
    task automatic t_jam(input logic [1:0] f, input int idx, input int c);
        fault = f;
        pick(c);
        step(int'(PTMO) - 2);
        check(o[idx], 1'b0);
        wait_bit(idx, 1'b1, 40);
        step(2);
        check(o[BUSY] | o[RS+c], 1'b0);
        pick(c);
        check(o[RS+c], 1'b0);
        if (f == 2'h2) begin
            wake_evt = 1'b1;
            step(1);
            wake_evt = 1'b0;
            wait_bit(RES, 1'b1, 6);
        end
        fault = 2'h0;
        step(45);
        clear_flags();
        check(o[idx] | o[RES], 1'b0);
    endtask
    task automatic t_door();
        pick(0);
        step(4);
        right_door_switch = 1'b1;
        wait_bit(DOOR, 1'b1, 6);
        step(1);
        check(o[BUSY], 1'b0);
        step(45);
        right_door_switch = 1'b0;
        step(6);
        check(o[RES], 1'b0);
        clear_flags();
        check(o[DOOR], 1'b0);
    endtask
    task automatic t_active_off();
        active_off = 1'b1;
        right_size_sensor = 1'b0;
        right_cassette_open_switch = 1'b1;
        right_liftup_surface_sensor = 1'b0;
        step(6);
        check(o[RP] & o[RA], 1'b1);
        active_off = 1'b0;
        wait_bit(RP, 1'b0, 6);
        right_cassette_open_switch = 1'b0;
        wait_bit(RM, 1'b1, 8);
        check(o[RP], 1'b1);
        check(o[RA], 1'b0);
        right_liftup_surface_sensor = 1'b1;
        wait_bit(RM, 1'b0, 6);
    endtask
    // clock and a cycle ceiling well above the several hundred cycles needed
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            final_report();
        end
    end
    initial begin
        {active_off, printing, wake_evt, jam_clear, fault} = '0;
        {right_liftup_surface_sensor, left_liftup_surface_sensor} = 2'h0;
        {right_pick_surface_sensor, left_pick_surface_sensor} = 2'h3;
        {right_size_sensor, left_size_sensor, right_door_switch} = 3'h4;
        {right_cassette_open_switch, left_cassette_open_switch} = 2'h0;
        {right_pick_req, left_pick_req} = 2'h0;
        sys_rst = 1'b1;
        step(3);
        sys_rst = 1'b0;
        t_power_lift();
        t_relift_fail();
        t_pick_ok(0);
        t_pick_ok(1);
        t_jam(2'h1, RJ1, 0);
        t_jam(2'h1, RJ1 + 1, 1);
        t_jam(2'h2, RJ3, 0);
        t_jam(2'h3, J4, 1);
        t_door();
        t_active_off();
        final_report();
    end
endmodule // tb_top
`default_nettype wire
